/* File: hw/wdt_pkg.sv */
// shared constants for the io port watchdog timer
// Overview of operation
// R01 - double unlock, then select logical device 08
// R02 - function_activate: 01 enables, 00 disables anytime
// R03 - timebase_select: 00h seconds, 08h minutes
// R04 - timeout_count holds count; 00h disables timeout
// R05 - each timeout_count write restarts from new value
// R06 - expiry asserts system reset automatically
// R07 - active nonzero count decrements per unit
package wdt_pkg;
	// ----------------------------------------------------------------
	// io ports and configuration protocol
	// ----------------------------------------------------------------
	localparam logic [15:0] IDX_PORT = 16'h002e;
	localparam logic [15:0] DAT_PORT = 16'h002f;
	localparam logic [7:0] UNLOCK_KEY = 8'h87;
	localparam logic [7:0] LOCK_KEY = 8'haa;
	localparam logic [7:0] WDT_LDN = 8'h08;
	localparam logic [7:0] IDLE_READ = 8'hff;
	// ----------------------------------------------------------------
	// register indexes
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_LDN = 8'h07;
	localparam logic [7:0] IDX_ACT = 8'h30;
	localparam logic [7:0] IDX_TB = 8'hf5;
	localparam logic [7:0] IDX_CNT = 8'hf6;
	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int ACT_BIT = 0;
	localparam int TB_MIN_BIT = 3;
	localparam logic [7:0] TB_SEC_VAL = 8'h00;
	localparam logic [7:0] TB_MIN_VAL = 8'h08;
	localparam logic [7:0] RST_REG = 8'h00;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int SEC_NS = 1000000000;
	localparam int CYC_PER_SEC = SEC_NS / CLK_PERIOD_NS;
	localparam int SECS_PER_MIN = 60;
	localparam int RST_HOLD_NS = 100000;
	localparam int RST_HOLD_CYC = RST_HOLD_NS / CLK_PERIOD_NS;
endpackage

/* File: hw/tick_if.sv */
// time base tick signals between the watchdog core and its divider
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
	logic clr;
	logic sec;
	logic min;
	modport gen (input clr, output sec, output min);
	modport use_side (output clr, input sec, input min);
endinterface
`default_nettype wire

/* File: hw/wdt_tick_gen.sv */
// divider that makes one-cycle second and minute enables
`timescale 1ns/1ps
`default_nettype none
module wdt_tick_gen #(
	parameter int CYC_PER_SEC = wdt_pkg::CYC_PER_SEC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// ticks
	tick_if.gen tk
);
	localparam int SW = $clog2(CYC_PER_SEC);

	logic [SW-1:0] sec_cnt_r;
	logic [5:0] min_cnt_r;
	logic sec_r;
	logic min_r;
	wire sec_wrap = (sec_cnt_r == SW'(CYC_PER_SEC - 1));
	wire min_wrap = (min_cnt_r == 6'(wdt_pkg::SECS_PER_MIN - 1));

	// clear restarts the partial unit so a reload gets full units
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sec_cnt_r <= '0;
			min_cnt_r <= '0;
			sec_r <= 1'b0;
			min_r <= 1'b0;
		end else if (tk.clr) begin
			sec_cnt_r <= '0;
			min_cnt_r <= '0;
			sec_r <= 1'b0;
			min_r <= 1'b0;
		end else begin
			sec_cnt_r <= sec_wrap ? '0 : sec_cnt_r + 1'b1;
			if (sec_wrap)
				min_cnt_r <= min_wrap ? '0 : min_cnt_r + 1'b1;
			sec_r <= sec_wrap;
			min_r <= sec_wrap && min_wrap;
		end
	end

	assign tk.sec = sec_r;
	assign tk.min = min_r;
endmodule
`default_nettype wire

/* File: hw/io_port_watchdog_timer.sv */
// watchdog timer reached through an index/data io port pair
`timescale 1ns/1ps
`default_nettype none
module io_port_watchdog_timer #(
	parameter int CYC_PER_SEC = wdt_pkg::CYC_PER_SEC,
	parameter int RST_HOLD_CYC = wdt_pkg::RST_HOLD_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// host io cycles
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	// system side
	output logic sys_rst,
	output logic cfg_mode
);
	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic [1:0] unl_cnt_r;
	logic [7:0] idx_r;
	logic [7:0] ldn_r;
	logic [7:0] act_r;
	logic [7:0] tb_r;
	logic [7:0] watchdog_counter_r;
	logic [7:0] rdata_r;
	logic sys_rst_r;
	// hold counter wide enough for the full reset pulse length
	localparam int HW = $clog2(RST_HOLD_CYC + 1);
	logic [HW-1:0] hold_r;

	tick_if tk ();

	wire is_cfg = (unl_cnt_r == 2'd2);
	wire wr_idx = io_wr && (io_addr == wdt_pkg::IDX_PORT);
	wire wr_dat = io_wr && (io_addr == wdt_pkg::DAT_PORT) && is_cfg;
	wire rd_idx = io_rd && (io_addr == wdt_pkg::IDX_PORT);
	wire rd_dat = io_rd && (io_addr == wdt_pkg::DAT_PORT);
	wire sel_wdt = (ldn_r == wdt_pkg::WDT_LDN);
	wire wr_ldn = wr_dat && (idx_r == wdt_pkg::IDX_LDN);
	wire wr_act = wr_dat && sel_wdt && (idx_r == wdt_pkg::IDX_ACT);
	wire wr_tb = wr_dat && sel_wdt && (idx_r == wdt_pkg::IDX_TB);
	wire wr_cnt = wr_dat && sel_wdt && (idx_r == wdt_pkg::IDX_CNT);
	wire active = act_r[wdt_pkg::ACT_BIT];
	wire run = active && (watchdog_counter_r != 8'h00);
	wire unit_tick = tb_r[wdt_pkg::TB_MIN_BIT] ? tk.min : tk.sec;
	wire dec = run && unit_tick && !wr_cnt;
	wire expire = dec && (watchdog_counter_r == 8'h01);

	// restart the time base on reload and whenever counting is idle
	assign tk.clr = wr_cnt || !run; // R05

	wdt_tick_gen #(.CYC_PER_SEC(CYC_PER_SEC)) u_tick (
		.mclk(mclk),
		.rstn(rstn),
		.tk(tk)
	);

	// ----------------------------------------------------------------
	// unlock sequence and index
	// ----------------------------------------------------------------
	// any other index write while locked breaks the key sequence
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			unl_cnt_r <= 2'd0;
			idx_r <= wdt_pkg::RST_REG;
		end else if (wr_idx) begin
			if (!is_cfg)
				unl_cnt_r <= (io_wdata == wdt_pkg::UNLOCK_KEY) ?
					unl_cnt_r + 2'd1 : 2'd0; // R01
			else if (io_wdata == wdt_pkg::LOCK_KEY)
				unl_cnt_r <= 2'd0;
			else
				idx_r <= io_wdata;
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ldn_r <= wdt_pkg::RST_REG;
			act_r <= wdt_pkg::RST_REG;
			tb_r <= wdt_pkg::TB_SEC_VAL;
		end else begin
			if (wr_ldn)
				ldn_r <= io_wdata; // R01
			if (wr_act)
				act_r <= io_wdata; // R02
			if (wr_tb)
				tb_r <= io_wdata; // R03
		end
	end

	// ----------------------------------------------------------------
	// countdown
	// ----------------------------------------------------------------
	// a reload in the same cycle as a unit tick wins: the host kept it alive
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			watchdog_counter_r <= wdt_pkg::RST_REG;
		else if (wr_cnt)
			watchdog_counter_r <= io_wdata; // R04 R05
		else if (dec)
			watchdog_counter_r <= watchdog_counter_r - 8'h01; // R07
	end

	// ----------------------------------------------------------------
	// system reset
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sys_rst_r <= 1'b0;
			hold_r <= '0;
		end else if (expire) begin
			sys_rst_r <= 1'b1; // R06
			hold_r <= HW'(RST_HOLD_CYC - 1);
		end else if (hold_r != '0) begin
			hold_r <= hold_r - 1'b1;
		end else begin
			sys_rst_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// read back
	// ----------------------------------------------------------------
	// reads of the timeout index show the live count, not the reload
	wire [7:0] dat_sel =
		!is_cfg ? wdt_pkg::IDLE_READ :
		(idx_r == wdt_pkg::IDX_LDN) ? ldn_r :
		!sel_wdt ? wdt_pkg::IDLE_READ :
		(idx_r == wdt_pkg::IDX_ACT) ? act_r :
		(idx_r == wdt_pkg::IDX_TB) ? tb_r :
		(idx_r == wdt_pkg::IDX_CNT) ? watchdog_counter_r :
		wdt_pkg::IDLE_READ;
	wire [7:0] rd_sel = rd_idx ? (is_cfg ? idx_r : wdt_pkg::IDLE_READ) :
		rd_dat ? dat_sel : wdt_pkg::IDLE_READ;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			rdata_r <= wdt_pkg::IDLE_READ;
		else if (io_rd)
			rdata_r <= rd_sel;
	end

	assign io_rdata = rdata_r;
	assign sys_rst = sys_rst_r;
	assign cfg_mode = is_cfg;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence key_write;
		wr_idx && (io_wdata == wdt_pkg::UNLOCK_KEY) && !is_cfg;
	endsequence
	// io cycles other than index port writes may fall between the two keys
	sequence first_key;
		(unl_cnt_r == 2'd0) ##0 key_write;
	endsequence
	sequence second_key;
		(unl_cnt_r == 2'd1) ##0 key_write;
	endsequence

	AST_KEY_ONE: assert property ( // R01
		first_key |=> unl_cnt_r == 2'd1)
		else $error("first unlock key not counted");
	AST_UNLOCK: assert property ( // R01
		second_key |=> is_cfg)
		else $error("two unlock keys did not open configuration");
	AST_KEY_BREAK: assert property ( // R01
		wr_idx && !is_cfg && (io_wdata != wdt_pkg::UNLOCK_KEY)
		|=> unl_cnt_r == 2'd0)
		else $error("a stray index value did not restart the unlock");
	AST_LDN: assert property ( // R01
		wr_ldn |=> ldn_r == $past(io_wdata))
		else $error("logical device select not stored");
	AST_REFUSE: assert property ( // R01
		io_wr && (io_addr == wdt_pkg::DAT_PORT) && !sel_wdt && !dec
		|=> $stable(watchdog_counter_r))
		else $error("count changed while another device was selected");
	AST_RD_LOCKED: assert property ( // R01
		rd_dat && !is_cfg |=> io_rdata == wdt_pkg::IDLE_READ)
		else $error("locked data read did not return the idle value");
	AST_RD_LDN: assert property ( // R01
		rd_dat && is_cfg && (idx_r == wdt_pkg::IDX_LDN)
		|=> io_rdata == $past(ldn_r))
		else $error("device select read back wrong");
	AST_ENABLE: assert property ( // R02
		wr_act && io_wdata[wdt_pkg::ACT_BIT] |=> active)
		else $error("activation write did not enable the watchdog");
	AST_DISABLE: assert property ( // R02
		wr_act && (io_wdata == 8'h00) |=> (!expire && !dec) [*2])
		else $error("countdown continued after disable");
	AST_SECOND: assert property ( // R03
		!tb_r[wdt_pkg::TB_MIN_BIT] && run && tk.sec && !wr_cnt |-> dec)
		else $error("second base missed a second tick");
	AST_MINUTE: assert property ( // R03
		tb_r[wdt_pkg::TB_MIN_BIT] && tk.sec && !tk.min |-> !dec)
		else $error("minute base counted on a bare second tick");
	AST_ZERO: assert property ( // R04
		(watchdog_counter_r == 8'h00) |-> !expire && !dec)
		else $error("zero count did not disable the timeout");
	AST_RELOAD: assert property ( // R05
		wr_cnt |=> watchdog_counter_r == $past(io_wdata) && !tk.sec)
		else $error("timeout write did not restart the countdown");
	AST_RESET: assert property ( // R06
		expire |=> sys_rst [*8])
		else $error("expiry did not hold system reset");
	AST_RISE: assert property ( // R06
		$rose(sys_rst) |-> $past(expire))
		else $error("system reset rose without an expiry");
	AST_DEC: assert property ( // R07
		dec |=> watchdog_counter_r == $past(watchdog_counter_r) - 8'h01)
		else $error("count did not step down on a unit tick");
	AST_EMPTY: assert property ( // R07
		expire |=> watchdog_counter_r == 8'h00)
		else $error("count not empty after expiry");
endmodule
`default_nettype wire

/* File: bench/io_host_model.sv */
// host processor model issuing index/data io port cycles
`timescale 1ns/1ps
`default_nettype none
module io_host_model (
	// clock
	input wire logic mclk,
	// io cycles
	output logic [15:0] io_addr,
	output logic io_wr,
	output logic io_rd,
	output logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata
);
	initial begin
		io_addr = 16'hffff;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
	end
	// ------------------------------------------------------------
	// single io cycles
	// ------------------------------------------------------------
	// released lines show the inverse so stale values never pass
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge mclk);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(negedge mclk);
		io_wr = 1'b0;
		io_addr = ~a;
		io_wdata = ~d;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge mclk);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge mclk);
		io_rd = 1'b0;
		io_addr = ~a;
		d = io_rdata;
	endtask
	// ------------------------------------------------------------
	// register accesses
	// ------------------------------------------------------------
	task automatic unlock();
		wr(wdt_pkg::IDX_PORT, wdt_pkg::UNLOCK_KEY);
		wr(wdt_pkg::IDX_PORT, wdt_pkg::UNLOCK_KEY);
	endtask
	// index then data forms one access; also used to restart the count
	task automatic reg_wr(input logic [7:0] i, input logic [7:0] v);
		wr(wdt_pkg::IDX_PORT, i);
		wr(wdt_pkg::DAT_PORT, v);
	endtask
	task automatic reg_rd(input logic [7:0] i, output logic [7:0] v);
		wr(wdt_pkg::IDX_PORT, i);
		rd(wdt_pkg::DAT_PORT, v);
	endtask
endmodule
`default_nettype wire

/* File: bench/tb_io_port_watchdog_timer.sv */
// self-checking bench for the io port watchdog timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_io_port_watchdog_timer;
	localparam int C = 20;
	localparam int H = 8;
	logic mclk;
	logic rstn;
	wire logic [15:0] io_addr;
	wire logic io_wr;
	wire logic io_rd;
	wire logic [7:0] io_wdata;
	wire logic [7:0] io_rdata;
	wire logic sys_rst;
	wire logic cfg_mode;
	int n_mismatch = 0;
	int checks_done = 0;
	int n;
	logic [7:0] v;
	io_port_watchdog_timer #(.CYC_PER_SEC(C), .RST_HOLD_CYC(H)) i_dut (
		.mclk(mclk), .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
		.sys_rst(sys_rst), .cfg_mode(cfg_mode));
	io_host_model i_host (.mclk(mclk), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata));
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task automatic give_verdict();
		if (n_mismatch == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ------------------------------------------------------------
	// waits, all bounded
	// ------------------------------------------------------------
	task automatic wait_rst(input int lim, output int k);
		k = 0;
		while (sys_rst !== 1'b1 && k < lim) begin
			@(negedge mclk);
			k++;
		end
		if (k >= lim) begin
			n_mismatch++;
			give_verdict();
		end
	endtask
	task automatic hold_len(output int k);
		k = 0;
		while (sys_rst === 1'b1 && k < 50) begin
			@(negedge mclk);
			k++;
		end
		if (k >= 50) begin
			n_mismatch++;
			give_verdict();
		end
	endtask
	task automatic quiet(input int k);
		logic bad;
		bad = 1'b0;
		repeat (k) begin
			@(negedge mclk);
			if (sys_rst !== 1'b0)
				bad = 1'b1;
		end
		`CHK(bad, 1'b0)
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		repeat (10) @(negedge mclk);
		rstn = 1'b1;
		`CHK({sys_rst, cfg_mode}, 2'b00)
		i_host.rd(wdt_pkg::DAT_PORT, v);
		`CHK(v, wdt_pkg::IDLE_READ)
		// a different index value between the keys restarts the unlock
		i_host.wr(wdt_pkg::IDX_PORT, wdt_pkg::UNLOCK_KEY);
		i_host.wr(wdt_pkg::IDX_PORT, wdt_pkg::IDX_LDN);
		i_host.wr(wdt_pkg::IDX_PORT, wdt_pkg::UNLOCK_KEY);
		`CHK(cfg_mode, 1'b0)
		i_host.wr(wdt_pkg::IDX_PORT, wdt_pkg::UNLOCK_KEY);
		`CHK(cfg_mode, 1'b1)
		i_host.reg_wr(wdt_pkg::IDX_CNT, 8'h05);
		i_host.reg_wr(wdt_pkg::IDX_LDN, wdt_pkg::WDT_LDN);
		i_host.reg_rd(wdt_pkg::IDX_LDN, v);
		`CHK(v, wdt_pkg::WDT_LDN)
		i_host.reg_rd(wdt_pkg::IDX_CNT, v);
		`CHK(v, 8'h00)
		i_host.rd(wdt_pkg::IDX_PORT, v);
		`CHK(v, wdt_pkg::IDX_CNT)
		i_host.reg_wr(wdt_pkg::IDX_TB, wdt_pkg::TB_SEC_VAL);
		i_host.reg_wr(wdt_pkg::IDX_ACT, 8'h01);
		i_host.reg_rd(wdt_pkg::IDX_ACT, v);
		`CHK(v, 8'h01)
		i_host.reg_wr(wdt_pkg::IDX_CNT, 8'h03);
		wait_rst(200, n);
		`CHK(n >= 3 * C && n <= 3 * C + 2, 1'b1)
		hold_len(n);
		`CHK(n, H)
		i_host.reg_wr(wdt_pkg::IDX_CNT, 8'h02);
		quiet(30);
		i_host.reg_wr(wdt_pkg::IDX_CNT, 8'h02);
		wait_rst(200, n);
		`CHK(n >= 2 * C && n <= 2 * C + 2, 1'b1)
		hold_len(n);
		`CHK(n, H)
		i_host.reg_wr(wdt_pkg::IDX_CNT, 8'h05);
		quiet(2 * C + 5);
		i_host.reg_rd(wdt_pkg::IDX_CNT, v);
		`CHK(v, 8'h03)
		i_host.reg_wr(wdt_pkg::IDX_ACT, 8'h00);
		quiet(150);
		i_host.reg_rd(wdt_pkg::IDX_CNT, v);
		`CHK(v, 8'h03)
		i_host.reg_wr(wdt_pkg::IDX_ACT, 8'h01);
		i_host.reg_wr(wdt_pkg::IDX_CNT, 8'h00);
		quiet(150);
		i_host.reg_wr(wdt_pkg::IDX_TB, wdt_pkg::TB_MIN_VAL);
		i_host.reg_rd(wdt_pkg::IDX_TB, v);
		`CHK(v, wdt_pkg::TB_MIN_VAL)
		i_host.reg_wr(wdt_pkg::IDX_CNT, 8'h01);
		wait_rst(1300, n);
		`CHK(n >= 60 * C && n <= 60 * C + 2, 1'b1)
		i_host.wr(wdt_pkg::IDX_PORT, wdt_pkg::LOCK_KEY);
		`CHK(cfg_mode, 1'b0)
		i_host.rd(wdt_pkg::DAT_PORT, v);
		`CHK(v, wdt_pkg::IDLE_READ)
		// a reset in mid-run drops the system reset at once
		`CHK(sys_rst, 1'b1)
		rstn = 1'b0;
		repeat (2) @(negedge mclk);
		`CHK({sys_rst, cfg_mode}, 2'b00)
		rstn = 1'b1;
		i_host.unlock();
		i_host.reg_wr(wdt_pkg::IDX_LDN, wdt_pkg::WDT_LDN);
		i_host.reg_rd(wdt_pkg::IDX_ACT, v);
		`CHK(v, wdt_pkg::RST_REG)
		give_verdict();
	end
endmodule
`default_nettype wire
